// File: src/voltage_detect_pkg.sv
package voltage_detect_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'hF85;
  localparam logic [11:0] FLAG_OFS = 12'hF86;
  localparam logic [11:0] MASK_OFS = 12'hF87;
  localparam logic [11:0] GIRQ_OFS = 12'hF88;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIR_BIT = 7;
  localparam int BGAP_BIT = 6;
  localparam int REF_BIT = 5;
  localparam int EN_BIT = 4;
  localparam int LVL_LSB = 0;
  localparam int LVL_W = 4;
  localparam int DETECT_BIT = 2;
  localparam int GIE_BIT = 7;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LVL_EXTERNAL = 4'hF;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    DIR_FALLING = 1'b0,
    DIR_RISING = 1'b1
  } direction_t;

endpackage : voltage_detect_pkg

// File: src/sync_stages.sv
`timescale 1ns/1ps
module sync_stages
  import voltage_detect_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int STAGES = SYNC_STAGES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] chain_q [STAGES];

  // first stage feeds only the next stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_q[i] <= '0;
      end
    end else begin
      chain_q[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        chain_q[i] <= chain_q[i-1];
      end
    end
  end

  assign sync_out = chain_q[STAGES-1];

endmodule : sync_stages

// File: src/trip_level_mux.sv
`timescale 1ns/1ps
module trip_level_mux
  import voltage_detect_pkg::*;
(
  // level select
  input wire logic [LVL_W-1:0] level_sel,
  // comparator results per divider tap, and for the external pin
  input wire logic [14:0] tap_above,
  input wire logic ext_above,
  // selected comparator result
  output logic sel_above
);

  // ---------------------------------------------------------------
  // sixteen-way selector
  // ---------------------------------------------------------------
  function automatic logic pick(input logic [LVL_W-1:0] sel,
                                input logic [15:0] taps);
    pick = taps[sel];
  endfunction : pick

  // top code routes the external input in place of the divider
  assign sel_above = pick(level_sel, {ext_above, tap_above}); // R7 R8

endmodule : trip_level_mux

// File: src/voltage_detect_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// R1: 8-bit control: direction, bandgap, reference, enable, level.
// R2: direction 0 watches supply at or below trip; 1 at or above.
// R3: detector powered only while detector_enable is set.
// R4: reference_stable is read-only, set once settled after each enable.
// R5: detect_flag cannot set until reference_stable is set.
// R6: bandgap_stable is read-only and reflects band-gap stability.
// R7: four-bit trip level selects one of sixteen trip points.
// R8: level all ones feeds the comparator from the external trip input.
// R9: a crossing in the selected direction sets detect_flag.
// R10: interrupt needs flag, detect_irq_enable and global_irq_enable set.
// R11: software clears detect_flag after enabling the detector.
// R12: software disables, sets level, direction, enables, then clears flag.
// R13: reference settling is an asynchronous ready input, not a count.
// R14: excursions during settling need not be caught.
// R15: detection runs in sleep; a crossing sets the flag and wakes (wake_q here also needs detect_irq_enable set).
// R16: reset clears every control bit, leaving the detector off.
// R17: clearing detector_enable clears reference_stable.
// R18: comparator and ready inputs pass two flip-flop stages.
// R19: detect_flag is sticky until software clears it.
module voltage_detect_ctrl
  import voltage_detect_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // analog comparator side, asynchronous
  input wire logic [14:0] tap_above,
  input wire logic ext_above,
  input wire logic ref_ready,
  input wire logic bandgap_ok,
  // analog control
  output logic detector_power_q,
  output logic [LVL_W-1:0] tap_select_q,
  output logic ext_input_sel_q,
  // system side
  output logic irq_q,
  output logic wake_q
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  direction_t dir_q;
  logic enable_q;
  logic [LVL_W-1:0] level_q;
  logic ref_stable_q;
  logic bandgap_q;
  logic flag_q;
  logic flag_d;
  logic irq_en_q;
  logic gie_q;
  logic sel_above;
  logic above_s;
  logic ready_s;
  logic bandgap_s;
  logic hit;
  logic ctrl_wr;
  logic flag_clr;
  logic [7:0] ctrl_view;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // ---------------------------------------------------------------
  // comparator selection and synchronisers
  // ---------------------------------------------------------------
  trip_level_mux u_mux (
    .level_sel(level_q),
    .tap_above(tap_above),
    .ext_above(ext_above),
    .sel_above(sel_above)
  );

  // ready is a level from the analog side, timed there, not here
  sync_stages #(
    .WIDTH(3),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({sel_above, ref_ready, bandgap_ok}), // R13 R18
    .sync_out({above_s, ready_s, bandgap_s}) // R18
  );

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  assign ctrl_wr = reg_wr && addr_is(reg_addr, CTRL_OFS);
  assign flag_clr = reg_wr && addr_is(reg_addr, FLAG_OFS) &&
                    reg_wdata[DETECT_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= DIR_FALLING; // R16
      enable_q <= CTRL_RST[EN_BIT]; // R16
      level_q <= CTRL_RST[LVL_LSB +: LVL_W]; // R16
    end else if (ctrl_wr) begin
      // status bits 6 and 5 are not written
      dir_q <= direction_t'(reg_wdata[DIR_BIT]); // R1 R2
      enable_q <= reg_wdata[EN_BIT]; // R1 R3
      level_q <= reg_wdata[LVL_LSB +: LVL_W]; // R1
    end
  end

  // outputs to the analog side mirror the control fields
  assign detector_power_q = enable_q; // R3
  assign tap_select_q = level_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_input_sel_q <= 1'b0;
    end else if (ctrl_wr) begin
      ext_input_sel_q <= (reg_wdata[LVL_LSB +: LVL_W] == LVL_EXTERNAL); // R8
    end
  end

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_stable_q <= 1'b0;
    end else if (!enable_q) begin
      ref_stable_q <= 1'b0; // R17
    end else if (ready_s) begin
      ref_stable_q <= 1'b1; // R4
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_q <= 1'b0;
    end else begin
      bandgap_q <= bandgap_s; // R6
    end
  end

  // ---------------------------------------------------------------
  // detection and sticky flag
  // ---------------------------------------------------------------
  // before settling the flag is held off, so brief excursions are lost
  assign hit = enable_q && ref_stable_q && // R5 R14
               ((dir_q == DIR_RISING) ? above_s : !above_s); // R2

  // set wins over a clear in the same cycle; runs in sleep as well
  assign flag_d = hit || (flag_q && !flag_clr); // R9 R15 R19

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d; // R19
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
    end else if (reg_wr && addr_is(reg_addr, MASK_OFS)) begin
      irq_en_q <= reg_wdata[DETECT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
    end else if (reg_wr && addr_is(reg_addr, GIRQ_OFS)) begin
      gie_q <= reg_wdata[GIE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // interrupt and wake
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= flag_q && irq_en_q && gie_q; // R10
      // wake needs only the local enable; vectoring needs the global
      wake_q <= flag_q && irq_en_q; // R15
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  assign ctrl_view = {dir_q, bandgap_q, ref_stable_q, enable_q, level_q};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CTRL_OFS: reg_rdata_q <= ctrl_view; // R1 R4 R6
        FLAG_OFS: reg_rdata_q <= {5'h00, flag_q, 2'h0};
        MASK_OFS: reg_rdata_q <= {5'h00, irq_en_q, 2'h0};
        GIRQ_OFS: reg_rdata_q <= {gie_q, 7'h00};
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ctrl_read_a: assert property ( // R1
    reg_rd && reg_addr == CTRL_OFS && !reg_wr |=>
      reg_rdata_q == $past(ctrl_view))
    else $error("control register read mismatch");

  dir_rise_a: assert property ( // R2
    $rose(flag_q) |-> $past(dir_q == DIR_RISING ? above_s : !above_s))
    else $error("flag set against selected direction");

  power_follow_a: assert property ( // R3
    ctrl_wr |=> detector_power_q == $past(reg_wdata[EN_BIT]))
    else $error("detector power does not follow enable write");

  ref_cause_a: assert property ( // R4
    $rose(ref_stable_q) |-> $past(enable_q && ready_s))
    else $error("reference stable set without ready");

  flag_needs_ref_a: assert property ( // R5
    $rose(flag_q) |-> $past(ref_stable_q && enable_q))
    else $error("flag set before reference stable");

  bandgap_track_a: assert property ( // R6
    bandgap_ok [*4] |-> bandgap_q)
    else $error("bandgap status lags more than four cycles");

  ext_sel_a: assert property ( // R8
    ctrl_wr |=> ext_input_sel_q ==
      ($past(reg_wdata[LVL_LSB +: LVL_W]) == LVL_EXTERNAL))
    else $error("external input select wrong");

  detect_set_a: assert property ( // R9
    hit |=> flag_q)
    else $error("crossing did not set flag");

  irq_gate_a: assert property ( // R10
    ##1 irq_q == $past(flag_q && irq_en_q && gie_q))
    else $error("interrupt not gated by both enables");

  wake_gate_a: assert property ( // R15
    flag_q && irq_en_q && !flag_clr |=> wake_q)
    else $error("wake missing for enabled flag");

  ref_drop_a: assert property ( // R17
    !enable_q |=> !ref_stable_q)
    else $error("reference stable kept while disabled");

  flag_sticky_a: assert property ( // R19
    flag_q && !flag_clr |=> flag_q)
    else $error("flag dropped without software clear");

  tap_mirror_a: assert property ( // R7
    ctrl_wr |=> tap_select_q == $past(reg_wdata[LVL_LSB +: LVL_W]))
    else $error("trip level select does not follow write");

  ref_sync_a: assert property ( // R13
    enable_q && ready_s |=> ref_stable_q)
    else $error("reference stable missed synced ready");

  flag_clear_a: assert property ( // R19
    flag_clr && !hit |=> !flag_q)
    else $error("software clear did not clear flag");

  rdata_idle_a: assert property ( // R1
    !reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data not zero outside read");

  irq_needs_gie_a: assert property ( // R10
    !gie_q |=> !irq_q)
    else $error("interrupt raised without global enable");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  rise_detect_c: cover property (
    dir_q == DIR_RISING && $rose(flag_q));
  fall_detect_c: cover property (
    dir_q == DIR_FALLING && $rose(flag_q));
  ext_detect_c: cover property (
    ext_input_sel_q && $rose(flag_q));
  set_clear_c: cover property (hit && flag_clr);
  irq_raised_c: cover property ($rose(irq_q));

endmodule : voltage_detect_ctrl

// File: bench/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model #(
  // lands off the clock edge, so the ready level never races it
  parameter int SETTLE_NS = 1030
) (
  // control from the detector
  input wire logic power_on,
  // analog conditions, millivolts
  input wire logic [15:0] supply_mv,
  input wire logic [15:0] ext_mv,
  input wire logic bg_good,
  // comparator and reference outputs
  output logic [14:0] tap_above,
  output logic ext_above,
  output logic ref_ready,
  output logic bandgap_ok
);
  // ---------------------------------------------------------------
  // divider taps and comparator
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      tap_above[i] = int'(supply_mv) > 2000 + 100 * i;
    end
    ext_above = int'(ext_mv) > 1200;
  end
  assign bandgap_ok = bg_good;
  // ---------------------------------------------------------------
  // reference settling, timed apart from the system clock
  // ---------------------------------------------------------------
  always begin
    ref_ready = 1'b0;
    wait (power_on === 1'b1);
    #(SETTLE_NS);
    ref_ready = power_on;
    wait (power_on !== 1'b1);
  end
endmodule : analog_front_model

// File: bench/tb_supply_voltage_detect_ctrl.sv
`timescale 1ns/1ps
module tb_supply_voltage_detect_ctrl;
  import voltage_detect_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, bg_good;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic [14:0] tap_above;
  logic ext_above, ref_ready, bandgap_ok, detector_power_q;
  logic ext_input_sel_q, irq_q, wake_q;
  logic [LVL_W-1:0] tap_select_q;
  logic [15:0] supply_mv, ext_mv;
  int error_cnt, samples_checked, bg, dir, seed_v;

  voltage_detect_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tap_above(tap_above),
    .ext_above(ext_above), .ref_ready(ref_ready),
    .bandgap_ok(bandgap_ok), .detector_power_q(detector_power_q),
    .tap_select_q(tap_select_q), .ext_input_sel_q(ext_input_sel_q),
    .irq_q(irq_q), .wake_q(wake_q));
  analog_front_model afe (.power_on(detector_power_q),
    .supply_mv(supply_mv), .ext_mv(ext_mv), .bg_good(bg_good),
    .tap_above(tap_above), .ext_above(ext_above), .ref_ready(ref_ready),
    .bandgap_ok(bandgap_ok));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // reference model and bus tasks
  // ---------------------------------------------------------------
  function automatic int hit(input int l, input int d);
    int above;
    above = (l == 15) ? int'(ext_mv > 1200) : int'(supply_mv > 2000 + 100 * l);
    return d ? above : int'(!above);
  endfunction : hit
  function automatic logic [7:0] cexp(input int d, r, en, l);
    return {d[0], bg[0], r[0], en[0], l[3:0]};
  endfunction : cexp
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // data stand in this cycle; taken as sampled at the next edge
    @(posedge sys_clk);
    check(n, reg_rdata_q, e);
  endtask : rchk
  task automatic cfg(input int l, input int d);
    wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'(l));
    wr(CTRL_OFS, {d[0], 3'h0, l[3:0]});
    wr(CTRL_OFS, {d[0], 3'h1, l[3:0]});
  endtask : cfg
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bg_good = 1'b0;
    bg = 0;
    supply_mv = 16'hCE4;
    ext_mv = 16'h3E8;
    seed_v = $urandom(34);
    cyc(10);
    rst_n <= 1'b1;
    rchk("ctrl_rst", CTRL_OFS, cexp(0, 0, 0, 0));
    check("power_rst", detector_power_q, 8'h00);
    rchk("unmapped", 12'h000, 8'h00);
    bg_good <= 1'b1;
    bg = 1;
    cyc(4);
    rchk("ctrl_bg", CTRL_OFS, cexp(0, 0, 0, 0));
    wr(CTRL_OFS, 8'hFF);
    rchk("ctrl_ro", CTRL_OFS, cexp(1, 0, 1, 15));
    check("ext_sel", ext_input_sel_q, 8'h01);
    check("power_on", detector_power_q, 8'h01);
    wr(CTRL_OFS, 8'h00);
    cyc(3);
    rchk("ctrl_off", CTRL_OFS, cexp(0, 0, 0, 0));
    supply_mv <= 16'h5DC;
    cfg(0, 0);
    rchk("flag_early", FLAG_OFS, 8'h00);
    rchk("ref_early", CTRL_OFS, cexp(0, 0, 1, 0));
    cyc(20);
    rchk("ref_set", CTRL_OFS, cexp(0, 1, 1, 0));
    rchk("flag_set", FLAG_OFS, 8'h04);
    supply_mv <= 16'hCE4;
    cyc(6);
    rchk("flag_sticky", FLAG_OFS, 8'h04);
    for (int m = 0; m < 4; m++) begin
      wr(MASK_OFS, m[0] ? 8'h04 : 8'h00);
      wr(GIRQ_OFS, m[1] ? 8'h80 : 8'h00);
      cyc(2);
      check("irq", irq_q, 8'(m == 3));
      check("wake", wake_q, 8'(m[0]));
    end
    wr(FLAG_OFS, 8'h04);
    cyc(2);
    rchk("flag_clr", FLAG_OFS, 8'h00);
    check("irq_clr", irq_q, 8'h00);
    wr(CTRL_OFS, 8'h00);
    rchk("ref_drop", CTRL_OFS, cexp(0, 0, 0, 0));
    for (int l = 0; l < 16; l++) begin
      dir = $urandom % 2;
      supply_mv <= 16'(1500 + $urandom % 3000);
      ext_mv <= 16'(700 + $urandom % 1000);
      cfg(l, dir);
      check("tap_sel", tap_select_q, 8'(l));
      check("ext_sel", ext_input_sel_q, 8'(l == 15));
      cyc(14);
      wr(FLAG_OFS, 8'h04);
      cyc(6);
      rchk("flag_lvl", FLAG_OFS, 8'(hit(l, dir) * 4));
    end
    rst_n <= 1'b0;
    cyc(2);
    check("power_rst2", detector_power_q, 8'h00);
    rst_n <= 1'b1;
    cyc(4);
    rchk("ctrl_rst2", CTRL_OFS, cexp(0, 0, 0, 0));
    rchk("flag_rst2", FLAG_OFS, 8'h00);
    end_sim();
  end
  initial begin
    cyc(5000);
    error_cnt++;
    end_sim();
  end
endmodule : tb_supply_voltage_detect_ctrl
